// >>> inc/wfb_pkg.sv
// Constants for the fixed-rate waveform capture fill control.
// Assumes a 2048-word sample memory mapped at 0x800..0xFFF.
package wfb_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 11;
  localparam int DATA_W = 32;
  localparam int CHANNELS = 7;
  localparam int SET_IDX_W = 8;
  localparam int PAGE_W = 4;
  localparam int PAGES = 16;
  localparam int TRIG_W = 11;
  localparam int EVENT_W = 10;
  localparam logic [ADDR_W-1:0] BUF_FIRST_ADDR = 12'h800;
  localparam logic [ADDR_W-1:0] BUF_LAST_ADDR = 12'hFFF;
  localparam int BUF_WORDS = 2048;
  localparam int SET_WORDS = 8;
  localparam int PAGE_WORDS = 128;
  localparam int CENTER_WORDS = 1024;
  localparam logic [2:0] IN_SLOT = 3'h6;
  localparam logic [2:0] SPARE_SLOT = 3'h7;
  localparam logic [3:0] SET_IN_PAGE_LAST = 4'hF;
  localparam logic [SET_IDX_W-1:0] LAST_SET = 8'hFF;
  localparam logic [SET_IDX_W-1:0] CENTER_SETS = 8'h80;
  localparam int SOFTWARE_FORCED_EVENT_BIT = 10;
  localparam logic [PAGE_W-1:0] LAST_PAGE_RST = 4'h0;
  localparam logic [ADDR_W-1:0] EVENT_ADDR_RST = 12'h000;
  typedef enum logic [1:0] {
    MODE_STOP_FULL = 2'b00,
    MODE_STOP_TRIG = 2'b01,
    MODE_CENTER_TRIG = 2'b10,
    MODE_SAVE_ADDR = 2'b11
  } fill_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_STOPPED = 2'b10
  } fill_state_t;
endpackage : wfb_pkg

// >>> inc/wfb_mem_if.sv
// Write and read ports between fill control and sample memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface wfb_mem_if;
  logic wr_en;
  logic [wfb_pkg::IDX_W-1:0] wr_idx;
  logic [wfb_pkg::DATA_W-1:0] wr_data;
  logic [wfb_pkg::IDX_W-1:0] rd_idx;
  logic [wfb_pkg::DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : wfb_mem_if

// >>> logic/wfb_sample_mem.sv
// Sample memory of 2048 words, one write and one registered read port.
// Assumes the fill control drives the write side and the host reads.
`timescale 1ns/1ns
module wfb_sample_mem #(
  parameter int WORDS = wfb_pkg::BUF_WORDS
) (
  input wire logic clock_i,
  wfb_mem_if.mem port
);
  logic [wfb_pkg::DATA_W-1:0] mem_ff [WORDS];

  // Contents are kept across capture disable, so no reset here
  always_ff @(posedge clock_i) begin
    if (port.wr_en) begin
      mem_ff[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge clock_i) begin
    port.rd_data <= mem_ff[port.rd_idx];
  end
endmodule : wfb_sample_mem

// >>> logic/wfb_fill_ctrl.sv
// Fill control for fixed-rate sample sets in the circular sample memory.
// Assumes sample sets arrive far apart (kilohertz rate) against 25 MHz.
//
// Function
// - Source select 1 with mode 00 selects stop-when-full filling.
// - Stop-when-full capture starts writing at location 0x800.
// - Stop-when-full stops once location 0xFFE, the last sample slot, has been written.
// - Page 15 indication enabled sets page-filled flag when buffer fills.
// - Source 1 with mode 1, 2 or 3 fills continuously from 0x800.
// - Continuous filling wraps from 0xFFF back to 0x800.
// - Continuous filling overwrites old samples whether read or not.
// - Mode 1 stops on trigger, mode 2 centres around trigger.
// - Stop-on-trigger fills circularly and stops on an enabled trigger.
// - Trigger enable bits: force, zero-crosses, overcurrent, swell, dip.
// - Event bits follow internal events; force bit itself triggers.
// - Trigger stop sets the trigger status flag.
// - Trigger stop stores neutral-slot address of last written set.
// - Sets above the stored address keep stale data after stop.
// - Host gets full history by arming triggers after page 15.
// - Stored address within two sets of event, last filled address.
// - Clearing capture enable resets last page and event address.
// - Buffer is 16 pages of 128 locations, one enable per page.
// - Page-filled flag set when an enabled page's last set completes.
// - Status field records the most recently filled page.
// - Sample set is seven samples plus one spare location.
`timescale 1ns/1ns
module wfb_fill_ctrl #(
  parameter int CHANNELS = wfb_pkg::CHANNELS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic capture_enable_bit_i,
  input wire logic capture_source_select_i,
  input wire logic [1:0] fill_mode_field_i,
  input wire logic [wfb_pkg::PAGES-1:0] page_indication_enable_i,
  input wire logic [wfb_pkg::TRIG_W-1:0] trigger_enable_reg_i,
  input wire logic [wfb_pkg::EVENT_W-1:0] trigger_events_i,
  input wire logic set_valid_i,
  input wire logic [CHANNELS*wfb_pkg::DATA_W-1:0] set_data_i,
  input wire logic [wfb_pkg::ADDR_W-1:0] host_rd_addr_i,
  input wire logic page_full_clr_i,
  input wire logic trigger_seen_clr_i,
  input wire logic trigger_stop_clr_i,
  output logic [wfb_pkg::DATA_W-1:0] host_rd_data_o,
  output logic [wfb_pkg::PAGE_W-1:0] last_filled_page_o,
  output logic [wfb_pkg::ADDR_W-1:0] event_address_field_o,
  output logic page_full_flag_o,
  output logic trigger_seen_flag_o,
  output logic trigger_stop_flag_o,
  output logic filling_o
);
  localparam int SW = wfb_pkg::SET_IDX_W;

  wfb_mem_if mem_bus ();

  wfb_sample_mem #(
    .WORDS(wfb_pkg::BUF_WORDS)
  ) u_mem (
    .clock_i(clock_i),
    .port(mem_bus.mem)
  );

  wfb_pkg::fill_state_t state_ff;
  wfb_pkg::fill_state_t nxt_state;
  wfb_pkg::fill_mode_t mode_ff;
  logic cap_en_q_ff;
  logic busy_ff;
  logic [2:0] slot_ff;
  logic [SW-1:0] set_idx_ff;
  logic [SW-1:0] last_set_ff;
  logic [SW-1:0] post_cnt_ff;
  logic [CHANNELS*wfb_pkg::DATA_W-1:0] set_buf_ff;
  logic triggered_ff;
  logic addr_pend_ff;
  logic stop_pend_ff;
  logic [wfb_pkg::PAGE_W-1:0] last_page_ff;
  logic [wfb_pkg::ADDR_W-1:0] event_addr_ff;
  logic page_full_ff;
  logic trig_seen_ff;
  logic trig_stop_ff;

  logic start;
  logic cap_off;
  logic set_accept;
  logic set_done;
  logic page_end;
  logic trig_armed;
  logic trig_hit;
  logic full_stop;
  logic center_stop;
  logic trig_stop_now;
  logic [wfb_pkg::PAGE_W-1:0] cur_page;

  // Rising edge of capture enable; source 0 (resampled) is not handled here
  assign start = capture_enable_bit_i && !cap_en_q_ff && capture_source_select_i;
  assign cap_off = !capture_enable_bit_i;
  assign cur_page = set_idx_ff[SW-1:SW-wfb_pkg::PAGE_W];

  assign set_done = busy_ff && (slot_ff == wfb_pkg::SPARE_SLOT);
  // page boundary
  // Disable in this cycle also zeroes the page field, so no flag either
  assign page_end = set_done && !cap_off &&
                    (set_idx_ff[3:0] == wfb_pkg::SET_IN_PAGE_LAST);

  assign trig_armed = (state_ff == wfb_pkg::ST_FILL) && capture_enable_bit_i &&
                      (mode_ff != wfb_pkg::MODE_STOP_FULL) && !triggered_ff;
  assign trig_hit = trig_armed &&
                    ((|(trigger_enable_reg_i[wfb_pkg::EVENT_W-1:0] & trigger_events_i)) ||
                     trigger_enable_reg_i[wfb_pkg::SOFTWARE_FORCED_EVENT_BIT]);

  assign full_stop = set_done && (mode_ff == wfb_pkg::MODE_STOP_FULL) &&
                     (set_idx_ff == wfb_pkg::LAST_SET);
  // Centre mode runs 1024 more locations after the trigger
  assign center_stop = set_done && (mode_ff == wfb_pkg::MODE_CENTER_TRIG) && triggered_ff &&
                       (post_cnt_ff == wfb_pkg::CENTER_SETS - 8'h01);
  // stop on trigger
  // Trigger in the spare-slot cycle sees a finished set, so stop at once
  assign trig_stop_now = (mode_ff == wfb_pkg::MODE_STOP_TRIG) &&
                         ((trig_hit && (!busy_ff || set_done)) ||
                          (set_done && stop_pend_ff));

  // Offers while busy or stopping are dropped; a set can be taken at most every 9 cycles
  assign set_accept = set_valid_i && (state_ff == wfb_pkg::ST_FILL) && !busy_ff &&
                      !stop_pend_ff && !trig_stop_now;

  // Reset low, so an enable held through reset still starts a fill
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cap_en_q_ff <= 1'b0;
    end else begin
      cap_en_q_ff <= capture_enable_bit_i;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      wfb_pkg::ST_IDLE: begin
        // restart needs a fresh enable edge
        if (start) begin
          nxt_state = wfb_pkg::ST_FILL;
        end
      end
      wfb_pkg::ST_FILL: begin
        if (cap_off) begin
          nxt_state = wfb_pkg::ST_IDLE;
        end else if (full_stop || center_stop || trig_stop_now) begin
          nxt_state = wfb_pkg::ST_STOPPED;
        end
      end
      wfb_pkg::ST_STOPPED: begin
        if (cap_off) begin
          nxt_state = wfb_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = wfb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_ff <= wfb_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Mode is taken at start; changing it mid-capture is not supported
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_ff <= wfb_pkg::MODE_STOP_FULL;
    end else if (start && state_ff == wfb_pkg::ST_IDLE) begin
      mode_ff <= wfb_pkg::fill_mode_t'(fill_mode_field_i);
    end
  end

  // Set writer: seven sample slots then one untouched spare slot
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      busy_ff <= 1'b0;
      slot_ff <= 3'h0;
    end else if (set_accept) begin
      busy_ff <= 1'b1;
      slot_ff <= 3'h0;
    end else if (set_done) begin
      busy_ff <= 1'b0;
      slot_ff <= 3'h0;
    end else if (busy_ff) begin
      slot_ff <= slot_ff + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      set_buf_ff <= '0;
    end else if (set_accept) begin
      set_buf_ff <= set_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      set_idx_ff <= '0;
      last_set_ff <= wfb_pkg::LAST_SET;
    end else if (start && state_ff == wfb_pkg::ST_IDLE) begin
      set_idx_ff <= '0;
      last_set_ff <= wfb_pkg::LAST_SET;
    end else if (set_done) begin
      last_set_ff <= set_idx_ff;
      set_idx_ff <= set_idx_ff + 8'h01;
    end
  end

  assign mem_bus.wr_en = busy_ff && (slot_ff != wfb_pkg::SPARE_SLOT) &&
                         (state_ff == wfb_pkg::ST_FILL);
  assign mem_bus.wr_idx = {set_idx_ff, slot_ff};
  assign mem_bus.wr_data = set_buf_ff[slot_ff*wfb_pkg::DATA_W +: wfb_pkg::DATA_W];
  // Top address bit is always set inside the buffer window
  assign mem_bus.rd_idx = host_rd_addr_i[wfb_pkg::IDX_W-1:0];
  assign host_rd_data_o = mem_bus.rd_data;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      triggered_ff <= 1'b0;
    end else if (start && state_ff == wfb_pkg::ST_IDLE) begin
      triggered_ff <= 1'b0;
    end else if (trig_hit) begin
      triggered_ff <= 1'b1;
    end
  end

  // A trigger in mid-set lets the set finish before stopping
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      stop_pend_ff <= 1'b0;
      addr_pend_ff <= 1'b0;
    end else if (set_done) begin
      stop_pend_ff <= 1'b0;
      addr_pend_ff <= 1'b0;
    end else if (trig_hit && busy_ff) begin
      stop_pend_ff <= (mode_ff == wfb_pkg::MODE_STOP_TRIG);
      addr_pend_ff <= 1'b1;
    end
  end

  // Count excludes the set in flight at the trigger
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      post_cnt_ff <= '0;
    end else if (start && state_ff == wfb_pkg::ST_IDLE) begin
      post_cnt_ff <= '0;
    end else if (set_done && triggered_ff && !addr_pend_ff) begin
      post_cnt_ff <= post_cnt_ff + 8'h01;
    end
  end

  // cleared with capture enable
  // One trigger per capture, so written at most once
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      event_addr_ff <= wfb_pkg::EVENT_ADDR_RST;
    end else if (set_done && (addr_pend_ff || trig_hit)) begin
      event_addr_ff <= {1'b1, set_idx_ff, wfb_pkg::IN_SLOT};
    end else if (trig_hit && !busy_ff) begin
      event_addr_ff <= {1'b1, last_set_ff, wfb_pkg::IN_SLOT};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || cap_off) begin
      last_page_ff <= wfb_pkg::LAST_PAGE_RST;
    end else if (page_end) begin
      last_page_ff <= cur_page;
    end
  end

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      page_full_ff <= 1'b0;
    end else begin
      page_full_ff <= (page_end && page_indication_enable_i[cur_page]) ||
                      (page_full_ff && !page_full_clr_i);
    end
  end

  // Seen flag rises on every accepted trigger, in all trigger modes
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trig_seen_ff <= 1'b0;
    end else begin
      trig_seen_ff <= trig_hit || (trig_seen_ff && !trigger_seen_clr_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trig_stop_ff <= 1'b0;
    end else begin
      trig_stop_ff <= (state_ff == wfb_pkg::ST_FILL && !cap_off &&
                       (trig_stop_now || center_stop)) ||
                      (trig_stop_ff && !trigger_stop_clr_i);
    end
  end

  assign last_filled_page_o = last_page_ff;
  assign event_address_field_o = event_addr_ff;
  assign page_full_flag_o = page_full_ff;
  assign trigger_seen_flag_o = trig_seen_ff;
  assign trigger_stop_flag_o = trig_stop_ff;
  // Low once stopped, so the host may poll it for the end of a capture
  assign filling_o = (state_ff == wfb_pkg::ST_FILL);
endmodule : wfb_fill_ctrl

// >>> tb/wfb_fill_ctrl_chk.sv
// Port-level checker for the fill control.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module wfb_fill_ctrl_chk (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic capture_enable_bit_i,
  input wire logic capture_source_select_i,
  input wire logic [1:0] fill_mode_field_i,
  input wire logic [wfb_pkg::PAGES-1:0] page_indication_enable_i,
  input wire logic [wfb_pkg::PAGE_W-1:0] last_filled_page_o,
  input wire logic [wfb_pkg::ADDR_W-1:0] event_address_field_o,
  input wire logic page_full_flag_o,
  input wire logic trigger_seen_flag_o,
  input wire logic trigger_stop_flag_o,
  input wire logic filling_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  a_fill_start: assert property (
    $rose(capture_enable_bit_i) && capture_source_select_i |=> filling_o) else $error("no start");
  a_src_refused: assert property (
    $rose(capture_enable_bit_i) && !capture_source_select_i |=> !filling_o) else $error("src");
  a_disable_clears: assert property (!capture_enable_bit_i |=> !filling_o &&
    last_filled_page_o == 4'h0 && event_address_field_o == 12'h000) else $error("no clear");
  a_start_rise: assert property ($rose(filling_o) |->
    $past(capture_enable_bit_i) && !$past(capture_enable_bit_i, 2)) else $error("restart");
  a_stop_flag: assert property (
    $rose(trigger_stop_flag_o) |-> $fell(filling_o)) else $error("stop flag");
  a_mode0_quiet: assert property (
    fill_mode_field_i == 2'h0 && !trigger_seen_flag_o |=> !trigger_seen_flag_o) else $error("m0");
  a_page_flag: assert property ($rose(page_full_flag_o) |->
    page_indication_enable_i[last_filled_page_o]) else $error("page flag");
  a_addr_kept: assert property (($past(event_address_field_o) != 12'h000 &&
    capture_enable_bit_i && $past(capture_enable_bit_i)) |-> $stable(event_address_field_o))
    else $error("addr moved");
  a_full_page: assert property ($fell(filling_o) && capture_enable_bit_i &&
    fill_mode_field_i == 2'h0 |-> last_filled_page_o == 4'hF) else $error("early stop");
  c_trig_stop: cover property ($rose(trigger_stop_flag_o));
  c_page_full: cover property ($rose(page_full_flag_o));
  c_seen_fill: cover property (trigger_seen_flag_o && filling_o);
endmodule : wfb_fill_ctrl_chk

bind wfb_fill_ctrl wfb_fill_ctrl_chk i_chk (.clock_i, .sys_rst_i, .capture_enable_bit_i,
  .capture_source_select_i, .fill_mode_field_i, .page_indication_enable_i, .last_filled_page_o,
  .event_address_field_o, .page_full_flag_o, .trigger_seen_flag_o, .trigger_stop_flag_o,
  .filling_o);

// >>> tb/wfb_host_model.sv
// Host side: reads buffer words through the read port.
// Assumes read data lands one cycle after the address.
`timescale 1ns/1ns
module wfb_host_model (
  input wire logic clock_i,
  output logic [11:0] host_rd_addr_o,
  input wire logic [31:0] host_rd_data_i
);
  initial host_rd_addr_o = 12'h800;
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    @(posedge clock_i);
    host_rd_addr_o <= a;
    repeat (2) @(posedge clock_i);
    q = host_rd_data_i;
  endtask : rd
endmodule : wfb_host_model

// >>> tb/tb_waveform_capture_fill_control.sv
// Self-checking bench for the fill control, host reads via the model.
// Assumes package, interface and design compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_waveform_capture_fill_control;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b0;
  logic src = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [15:0] pg = 16'h8000;
  logic [10:0] trg = 11'h000;
  logic [9:0] ev = 10'h000;
  logic sv = 1'b0;
  logic [223:0] sd = '0;
  logic clr = 1'b0;
  logic [11:0] ra;
  logic [31:0] rdat, d;
  logic [3:0] lp;
  logic [11:0] ea;
  logic pf, ts, tp, fl;
  int err_total = 0;
  int cmp_count = 0;
  always #20 clock_i = ~clock_i;
  wfb_fill_ctrl i_dut (.clock_i, .sys_rst_i, .capture_enable_bit_i(en),
    .capture_source_select_i(src), .fill_mode_field_i(mode), .page_indication_enable_i(pg),
    .trigger_enable_reg_i(trg), .trigger_events_i(ev), .set_valid_i(sv), .set_data_i(sd),
    .host_rd_addr_i(ra), .page_full_clr_i(clr), .trigger_seen_clr_i(clr),
    .trigger_stop_clr_i(clr), .host_rd_data_o(rdat), .last_filled_page_o(lp),
    .event_address_field_o(ea), .page_full_flag_o(pf), .trigger_seen_flag_o(ts),
    .trigger_stop_flag_o(tp), .filling_o(fl));
  wfb_host_model i_host (.clock_i, .host_rd_addr_o(ra), .host_rd_data_i(rdat));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic cfg(input logic [1:0] m, input logic [10:0] t);
    @(posedge clock_i);
    en <= 1'b0;
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    mode <= m;
    trg <= t;
    cyc(2);
    en <= 1'b1;
    cyc(2);
  endtask : cfg
  // Word k of set i is base + 16i + k
  task automatic send(input int n, input logic [31:0] b);
    logic [223:0] v;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 7; k++) v[32*k +: 32] = b + 32'(i * 16 + k);
      @(posedge clock_i);
      sv <= 1'b1;
      sd <= v;
      @(posedge clock_i);
      sv <= 1'b0;
      cyc(8);
    end
  endtask : send
  task automatic evp(input logic [9:0] e);
    @(posedge clock_i);
    ev <= e;
    @(posedge clock_i);
    ev <= 10'h000;
    cyc(2);
  endtask : evp
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    i_host.rd(a, d);
    `CHK(d, e)
  endtask : rdc
  task automatic t_stop_full();
    cfg(2'h0, 11'h001);
    evp(10'h001);
    send(256, 32'h1000_0000);
    cyc(3);
    `CHK(fl, 1'b0)
    `CHK(pf, 1'b1)
    `CHK(lp, 4'hF)
    `CHK(ts, 1'b0)
    send(1, 32'hBAD0_0000);
    rdc(12'h800, 32'h1000_0000);
    rdc(12'hFFE, 32'h1000_0FF6);
    $display("done stop_full");
  endtask : t_stop_full
  task automatic t_stop_trig();
    cfg(2'h1, 11'h001);
    `CHK(lp, 4'h0)
    `CHK(ea, 12'h000)
    send(3, 32'h2000_0000);
    `CHK(pf, 1'b0)
    evp(10'h002);
    `CHK(fl, 1'b1)
    evp(10'h001);
    `CHK(fl, 1'b0)
    `CHK(tp, 1'b1)
    `CHK(ea, 12'h816)
    send(1, 32'hBAD0_0000);
    evp(10'h001);
    `CHK(ea, 12'h816)
    rdc(12'h818, 32'h1000_0030);
    rdc(12'h816, 32'h2000_0026);
    $display("done stop_trig");
  endtask : t_stop_trig
  task automatic t_center();
    cfg(2'h2, 11'h200);
    `CHK(tp, 1'b0)
    send(2, 32'h3000_0000);
    evp(10'h200);
    `CHK(ts, 1'b1)
    `CHK(ea, 12'h80E)
    send(127, 32'h3100_0000);
    `CHK(fl, 1'b1)
    send(1, 32'h3200_0000);
    cyc(2);
    `CHK(fl, 1'b0)
    `CHK(tp, 1'b1)
    $display("done center");
  endtask : t_center
  task automatic t_wrap();
    cfg(2'h3, 11'h000);
    send(258, 32'h4000_0000);
    `CHK(fl, 1'b1)
    `CHK(lp, 4'hF)
    rdc(12'h800, 32'h4000_1000);
    rdc(12'h810, 32'h4000_0020);
    for (int b = 0; b < 10; b++) begin
      cfg(2'h3, 11'(1 << b));
      send(1, 32'h5000_0000);
      evp(10'(1 << b));
      `CHK(ea, 12'h806)
      `CHK(fl, 1'b1)
    end
    $display("done wrap");
  endtask : t_wrap
  // Triggers armed only after page 15; trigger lands in mid-set
  task automatic t_history();
    cfg(2'h1, 11'h000);
    send(256, 32'h6000_0000);
    cyc(2);
    `CHK(pf, 1'b1)
    `CHK(lp, 4'hF)
    `CHK(fl, 1'b1)
    @(posedge clock_i);
    trg <= 11'h004;
    sv <= 1'b1;
    sd <= {7{32'h6100_0006}};
    @(posedge clock_i);
    sv <= 1'b0;
    ev <= 10'h004;
    @(posedge clock_i);
    ev <= 10'h000;
    cyc(10);
    `CHK(fl, 1'b0)
    `CHK(tp, 1'b1)
    `CHK(ea, 12'h806)
    rdc(12'h806, 32'h6100_0006);
    rdc(12'h808, 32'h6000_0010);
    $display("done history");
  endtask : t_history
  task automatic t_force();
    cfg(2'h1, 11'h400);
    cyc(2);
    `CHK(fl, 1'b0)
    `CHK(ea, 12'hFFE)
    cfg(2'h1, 11'h000);
    `CHK(fl, 1'b1)
    @(posedge clock_i);
    src <= 1'b0;
    cfg(2'h0, 11'h000);
    `CHK(fl, 1'b0)
    $display("done force");
  endtask : t_force
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    cyc(20);
    sys_rst_i <= 1'b0;
    t_stop_full();
    t_stop_trig();
    t_center();
    t_wrap();
    t_history();
    t_force();
    close_out();
  end
  initial begin
    cyc(20000);
    err_total++;
    close_out();
  end
endmodule : tb_waveform_capture_fill_control
